// ---- rtl/rcsw_pkg.sv ----
// package for the radio core sleep and wake-up sequencer
// assumes one 125 MHz core clock; the slow clock arrives as a pin and is sampled
package rcsw_pkg;

	localparam int unsigned RCSW_CNT_W  = 32;
	localparam int unsigned RCSW_LEAD_W = 16;
	localparam int unsigned RCSW_EXT_W  = 8;

	localparam logic [RCSW_LEAD_W-1:0] RCSW_LEAD_RST    = 16'h0000;
	localparam logic [RCSW_LEAD_W-1:0] RCSW_RELEASE_RST = 16'h0001;
	localparam logic [RCSW_EXT_W-1:0]  RCSW_EXT_RST     = 8'h02;

	// slot reference: 625 us, counted in slow cycles at 32.0 kHz => 20 cycles
	localparam int unsigned RCSW_SLOT_NS       = 625000;
	localparam int unsigned RCSW_SLOW_PERIOD_NS = 31250;
	localparam logic [7:0]  RCSW_SLOT_CYCLES   = 8'(RCSW_SLOT_NS / RCSW_SLOW_PERIOD_NS);

	typedef struct packed {
		logic [RCSW_LEAD_W-1:0] wake_lead_cycles;
		logic [RCSW_LEAD_W-1:0] wake_release_cycles;
		logic [RCSW_EXT_W-1:0]  ext_wake_high_cycles;
	} rcsw_wake_irq_timing_s;

	typedef struct packed {
		logic sleep_enter;
		logic ext_wake_disable;
		logic sw_wake_request;
		logic core_clk_enable;
		logic radio_domain_up;
	} rcsw_ctrl_s;

	typedef enum logic [2:0] {
		RCSW_ACTIVE,
		RCSW_SWITCHING,
		RCSW_SLEEP,
		RCSW_EXPIRED,
		RCSW_EXITING
	} rcsw_state_e;

endpackage

// ---- rtl/rcsw_sleep_wakeup.sv ----
// deep-sleep entry and wake-up sequencer for the radio core
// assumes software drives the control ports directly; slow clock is a pin input
module rcsw_sleep_wakeup
	import rcsw_pkg::*;
#(
	parameter int unsigned CNT_W = RCSW_CNT_W
) (
	input  wire logic                           i_clk,
	input  wire logic                           i_resetn,
	input  wire logic                           i_sleep_slow_clock,
	input  wire rcsw_pkg::rcsw_wake_irq_timing_s i_wake_irq_timing_reg,
	input  wire logic [CNT_W-1:0]               i_sleep_duration_value,
	input  wire rcsw_pkg::rcsw_ctrl_s           i_ctrl,
	output logic                                o_early_wake_irq,
	output logic                                o_sleep_exit_irq,
	output logic                                o_radio_off_permitted,
	output logic                                o_in_deep_sleep,
	output logic [CNT_W-1:0]                    o_measured_sleep_reg,
	output logic [7:0]                          o_slot_phase
);
	import rcsw_pkg::*;

	// the counter must hold every lead and release count and fit the status port
	if (CNT_W < RCSW_LEAD_W) begin : g_cnt_w_small
		$error("rcsw_sleep_wakeup: CNT_W narrower than the lead count");
	end

	if (CNT_W > 32) begin : g_cnt_w_large
		$error("rcsw_sleep_wakeup: CNT_W wider than 32");
	end

	// the external high-time counter is compared in lead width
	if (RCSW_EXT_W > RCSW_LEAD_W) begin : g_ext_w_large
		$error("rcsw_sleep_wakeup: external count wider than the lead count");
	end

	// a zero-length slot would let the phase counter run through all 256 values
	if (RCSW_SLOT_CYCLES == 8'h00) begin : g_slot_zero
		$error("rcsw_sleep_wakeup: slot length is zero");
	end

	// ****************************************************
	// slow clock sampling
	// ****************************************************
	logic [2:0] slow_sync_reg;
	logic       slow_level_reg;
	logic       slow_tick;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			slow_sync_reg <= 3'h0;
		else
			slow_sync_reg <= {slow_sync_reg[1:0], i_sleep_slow_clock};
	end

	// a change is taken only once stages two and three agree
	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			slow_level_reg <= 1'h0;
		else if (slow_sync_reg[1] == slow_sync_reg[2])
			slow_level_reg <= slow_sync_reg[2];
	end

	assign slow_tick = (slow_sync_reg[1] == slow_sync_reg[2]) && slow_sync_reg[2] && !slow_level_reg;

	// ****************************************************
	// wake request handling
	// ****************************************************
	logic wake_req_eff;
	logic wake_req_d_reg;
	logic wake_req_rise;

	assign wake_req_eff = i_ctrl.sw_wake_request && !i_ctrl.ext_wake_disable;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			wake_req_d_reg <= 1'h0;
		else
			wake_req_d_reg <= wake_req_eff;
	end

	assign wake_req_rise = wake_req_eff && !wake_req_d_reg;

	// ****************************************************
	// sequencer
	// ****************************************************
	rcsw_state_e      state_reg;
	rcsw_state_e      state_next;
	logic [CNT_W-1:0] elapsed_reg;
	logic [CNT_W-1:0] duration_reg;
	logic [CNT_W-1:0] remaining;
	logic             timer_done;
	logic             ext_wake_reg;
	logic [RCSW_EXT_W-1:0] ext_cnt_reg;
	logic             lead_hit;
	logic             release_hit;
	logic             exit_ok;

	// remaining cycles until the programmed duration; saturates at zero
	assign remaining = (elapsed_reg >= duration_reg) ? '0 : duration_reg - elapsed_reg;
	assign timer_done = (elapsed_reg >= duration_reg) || ext_wake_reg;
	assign lead_hit = remaining <= CNT_W'(i_wake_irq_timing_reg.wake_lead_cycles);
	assign release_hit = remaining <= CNT_W'(i_wake_irq_timing_reg.wake_release_cycles);
	// clocks and radio both needed; waiting here lengthens the measured sleep
	assign exit_ok = timer_done && i_ctrl.core_clk_enable && i_ctrl.radio_domain_up;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RCSW_ACTIVE: begin
				if (i_ctrl.sleep_enter && !wake_req_eff)
					state_next = RCSW_SWITCHING;
			end
			RCSW_SWITCHING: begin
				// switch completes on the first rising slow edge, keeping the slot phase
				if (slow_tick)
					state_next = RCSW_SLEEP;
			end
			RCSW_SLEEP: begin
				if (timer_done)
					state_next = RCSW_EXPIRED;
			end
			RCSW_EXPIRED: begin
				// early wake irq must be low again before the exit irq
				if (exit_ok && !o_early_wake_irq)
					state_next = RCSW_EXITING;
			end
			RCSW_EXITING: begin
				state_next = RCSW_ACTIVE;
			end
			default: begin
				state_next = RCSW_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			state_reg <= RCSW_ACTIVE;
		else
			state_reg <= state_next;
	end

	// ****************************************************
	// sleep timer
	// ****************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			elapsed_reg  <= '0;
			duration_reg <= '0;
		end else if (state_reg == RCSW_ACTIVE && state_next == RCSW_SWITCHING) begin
			elapsed_reg  <= '0;
			duration_reg <= i_sleep_duration_value;
		end else if ((state_reg == RCSW_SLEEP || state_reg == RCSW_EXPIRED) && slow_tick) begin
			// keeps counting while waiting for power, so overrun is measured
			if (elapsed_reg != '1)
				elapsed_reg <= elapsed_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			o_measured_sleep_reg <= '0;
		else if (state_reg == RCSW_EXITING)
			o_measured_sleep_reg <= elapsed_reg;
	end

	// ****************************************************
	// early wake interrupt
	// ****************************************************
	logic                   early_fired_reg;
	logic [RCSW_LEAD_W-1:0] ext_cnt_wide;
	logic [RCSW_LEAD_W-1:0] release_plus_one;
	logic                   ext_step;
	logic                   ext_drop;

	// compared in lead width so a large release count is not cut to the
	// external field's width; a release count of all ones wraps to zero, so the count never steps
	// and the irq drops only if the external count is zero
	assign ext_cnt_wide     = RCSW_LEAD_W'(ext_cnt_reg);
	assign release_plus_one = i_wake_irq_timing_reg.wake_release_cycles + RCSW_LEAD_W'(1);
	assign ext_step = ext_wake_reg && slow_tick &&
		(ext_cnt_wide > i_wake_irq_timing_reg.wake_release_cycles);
	assign ext_drop = ext_wake_reg && slow_tick && (ext_cnt_wide <= release_plus_one);

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			ext_wake_reg <= 1'h0;
			ext_cnt_reg  <= '0;
		end else if (state_reg == RCSW_ACTIVE) begin
			ext_wake_reg <= 1'h0;
		end else if (wake_req_rise && !ext_wake_reg &&
			(state_reg == RCSW_SLEEP || state_reg == RCSW_SWITCHING)) begin
			ext_wake_reg <= 1'h1;
			ext_cnt_reg  <= i_wake_irq_timing_reg.ext_wake_high_cycles;
		end else if (ext_step) begin
			ext_cnt_reg <= ext_cnt_reg - RCSW_EXT_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_early_wake_irq <= 1'h0;
			early_fired_reg  <= 1'h0;
		end else if (state_reg == RCSW_ACTIVE) begin
			o_early_wake_irq <= 1'h0;
			early_fired_reg  <= 1'h0;
		end else if (wake_req_rise && !ext_wake_reg && !early_fired_reg) begin
			o_early_wake_irq <= 1'h1;
			early_fired_reg  <= 1'h1;
		end else if (ext_wake_reg) begin
			// held for ext count minus release cycles
			if (ext_drop)
				o_early_wake_irq <= 1'h0;
		end else if (state_reg == RCSW_SLEEP || state_reg == RCSW_EXPIRED) begin
			if (!early_fired_reg && (lead_hit || timer_done)) begin
				o_early_wake_irq <= 1'h1;
				early_fired_reg  <= 1'h1;
			end else if (early_fired_reg && (release_hit || timer_done) && slow_tick) begin
				o_early_wake_irq <= 1'h0;
			end
		end
	end

	// ****************************************************
	// exit interrupt, status and slot phase
	// ****************************************************
	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			o_sleep_exit_irq <= 1'h0;
		else
			o_sleep_exit_irq <= (state_reg == RCSW_EXITING);
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			o_radio_off_permitted <= 1'h0;
		else
			o_radio_off_permitted <= (state_next == RCSW_SLEEP || state_next == RCSW_EXPIRED);
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			o_in_deep_sleep <= 1'h0;
		else
			o_in_deep_sleep <= (state_next != RCSW_ACTIVE);
	end

	// slot reference kept on the slow clock while asleep
	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			o_slot_phase <= 8'h00;
		else if (o_in_deep_sleep && slow_tick)
			o_slot_phase <= (o_slot_phase >= RCSW_SLOT_CYCLES - 8'h01) ? 8'h00 : o_slot_phase + 8'h01;
	end

endmodule

// ---- bench/rcsw_sleep_wakeup_asserts.sv ----
// port assertions for the deep-sleep sequencer, bound to every instance
// assumes software keeps clocks and radio power up from exit to next entry
module rcsw_sleep_wakeup_chk
	import rcsw_pkg::*;
#(
	parameter int unsigned CNT_W = RCSW_CNT_W
) (
	input wire logic                           i_clk,
	input wire logic                           i_resetn,
	input wire logic                           i_sleep_slow_clock,
	input wire rcsw_pkg::rcsw_wake_irq_timing_s i_wake_irq_timing_reg,
	input wire logic [CNT_W-1:0]               i_sleep_duration_value,
	input wire rcsw_pkg::rcsw_ctrl_s           i_ctrl,
	input wire logic                           o_early_wake_irq,
	input wire logic                           o_sleep_exit_irq,
	input wire logic                           o_radio_off_permitted,
	input wire logic                           o_in_deep_sleep,
	input wire logic [CNT_W-1:0]               o_measured_sleep_reg,
	input wire logic [7:0]                     o_slot_phase
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// ****
	// helper: early irq seen during the current sleep
	// ****
	logic seen_early_reg;
	always_ff @(posedge i_clk)
		if (!i_resetn || !o_in_deep_sleep) seen_early_reg <= 1'b0;
		else if (o_early_wake_irq) seen_early_reg <= 1'b1;
	sequence s_entered;
		!o_in_deep_sleep ##1 o_in_deep_sleep;
	endsequence
	property p_early_first; o_sleep_exit_irq |-> seen_early_reg; endproperty
	a_early_first: assert property (p_early_first) else $error("exit irq without early irq");
	property p_exit_ready;
		o_sleep_exit_irq |-> $past(i_ctrl.core_clk_enable, 2) && $past(i_ctrl.radio_domain_up, 2);
	endproperty
	a_exit_ready: assert property (p_exit_ready) else $error("exit while unpowered");
	property p_exit_shape;
		o_sleep_exit_irq |-> !o_in_deep_sleep && $past(o_in_deep_sleep) ##1 !o_sleep_exit_irq;
	endproperty
	a_exit_shape: assert property (p_exit_shape) else $error("bad exit pulse");
	property p_hold_asleep; o_in_deep_sleep && !i_ctrl.core_clk_enable |=> o_in_deep_sleep; endproperty
	a_hold_asleep: assert property (p_hold_asleep) else $error("left sleep with clocks off");
	property p_refuse;
		!o_in_deep_sleep && i_ctrl.sw_wake_request && !i_ctrl.ext_wake_disable |=> !o_in_deep_sleep;
	endproperty
	a_refuse: assert property (p_refuse) else $error("slept under wake request");
	property p_wake_now;
		o_radio_off_permitted && $rose(i_ctrl.sw_wake_request) && !i_ctrl.ext_wake_disable
			|=> o_early_wake_irq;
	endproperty
	a_wake_now: assert property (p_wake_now) else $error("wake request not answered");
	property p_off_soon; s_entered |-> ##[1:60] o_radio_off_permitted; endproperty
	a_off_soon: assert property (p_off_soon) else $error("slow clock switch missing");
	property p_slot; o_slot_phase < RCSW_SLOT_CYCLES; endproperty
	a_slot: assert property (p_slot) else $error("slot phase out of range");
endmodule
bind rcsw_sleep_wakeup rcsw_sleep_wakeup_chk #(.CNT_W(CNT_W)) i_chk (.*);

// ---- bench/rcsw_sw_model.sv ----
// software stand-in that gates core clocks and radio power around sleep
// assumes the sequencer's core clock and reset
module rcsw_sw_model (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_early_wake_irq,
	input  wire logic        i_radio_off_permitted,
	input  wire logic [31:0] i_wake_delay,
	output logic             o_clk_en,
	output logic             o_radio_up
);
	logic [31:0] cnt_reg;
	logic        woke_reg;
	logic        gated_reg;
	// clocks are stopped at most once per sleep, so a wake is never undone
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_clk_en <= 1'b1;
			o_radio_up <= 1'b1;
			cnt_reg <= 32'h0;
			woke_reg <= 1'b0;
			gated_reg <= 1'b0;
		end else if (!i_radio_off_permitted) begin
			cnt_reg <= 32'h0;
			woke_reg <= 1'b0;
			gated_reg <= 1'b0;
		end else begin
			if (i_early_wake_irq)
				woke_reg <= 1'b1;
			if (!gated_reg && !woke_reg && !i_early_wake_irq) begin
				o_clk_en <= 1'b0;
				gated_reg <= 1'b1;
			end else if (gated_reg && !woke_reg && !i_early_wake_irq && o_radio_up) begin
				o_radio_up <= 1'b0;
			end else if ((woke_reg || i_early_wake_irq) && !o_clk_en) begin
				cnt_reg <= cnt_reg + 32'h1;
				// a long delay stands for slow handler code; sleep then runs over
				if (cnt_reg >= i_wake_delay) begin
					o_clk_en <= 1'b1;
					o_radio_up <= 1'b1;
					cnt_reg <= 32'h0;
				end
			end
		end
	end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the deep-sleep sequencer
// assumes a slow clock pin 40 core cycles per period, free running
`define CHK(nm, ex, sn) begin num_checks++; if ((sn) !== (ex)) begin n_errors++; \
	$display("MISMATCH %s exp %0h seen %0h", nm, ex, sn); end end
`define WAITS(nm, c) begin for (int k = 0; k < 6000 && !(c); k++) begin @(posedge clk); #1; end \
	`CHK(nm, 1'b1, (c)) end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rcsw_pkg::*;
	logic        clk = 0, resetn = 0, slow = 0, enter = 0, wdis = 0, wreq = 0;
	logic        clk_en, radio_up, early, exit_irq, roff, asleep;
	logic [31:0] dur = 32'h8, dly = 32'h5, meas;
	logic [7:0]  phase;
	int          n_errors = 0, num_checks = 0;
	rcsw_wake_irq_timing_s tmg = '{16'h3, 16'h1, 8'h2};
	rcsw_ctrl_s            ctrl;
	assign ctrl = '{enter, wdis, wreq, clk_en, radio_up};
	rcsw_sleep_wakeup i_dut (.i_clk(clk), .i_resetn(resetn), .i_sleep_slow_clock(slow),
		.i_wake_irq_timing_reg(tmg), .i_sleep_duration_value(dur), .i_ctrl(ctrl),
		.o_early_wake_irq(early), .o_sleep_exit_irq(exit_irq), .o_radio_off_permitted(roff),
		.o_in_deep_sleep(asleep), .o_measured_sleep_reg(meas), .o_slot_phase(phase));
	rcsw_sw_model i_sw (.i_clk(clk), .i_resetn(resetn), .i_early_wake_irq(early),
		.i_radio_off_permitted(roff), .i_wake_delay(dly), .o_clk_en(clk_en), .o_radio_up(radio_up));
	initial forever #4 clk = ~clk;
	initial begin
		#1;
		forever #160 slow = ~slow;
	end
	// ****
	// scenarios
	// ****
	task t_sleep(input logic [31:0] d, input logic [31:0] dl);
		@(posedge clk) dur <= d;
		dly <= dl;
		@(posedge clk) enter <= 1'b1;
		@(posedge clk) enter <= 1'b0;
		`WAITS("radio_off", roff)
	endtask
	task t_exit(input logic [31:0] lo, input logic [31:0] hi);
		`WAITS("exit_irq", exit_irq)
		`CHK("early_at_exit", 1'b0, early)
		`CHK("meas_lo", 1'b1, meas >= lo)
		`CHK("meas_hi", 1'b1, meas < hi)
		`CHK("slot_range", 1'b1, phase < RCSW_SLOT_CYCLES)
	endtask
	task t_timed;
		t_sleep(32'h8, 32'h5);
		t_exit(32'h8, 32'h20);
	endtask
	task t_late;
		t_sleep(32'h8, 32'hfa0);
		t_exit(32'h40, 32'hffff);
	endtask
	task t_ext;
		t_sleep(32'h3e8, 32'h5);
		repeat (20) @(posedge clk);
		wreq <= 1'b1;
		@(posedge clk);
		#1 `CHK("early_now", 1'b1, early)
		t_exit(32'h0, 32'h3e8);
		@(posedge clk) wreq <= 1'b0;
	endtask
	task t_refuse;
		@(posedge clk) wreq <= 1'b1;
		@(posedge clk) enter <= 1'b1;
		@(posedge clk) enter <= 1'b0;
		repeat (4) @(posedge clk);
		#1 `CHK("refused", 1'b0, asleep)
		@(posedge clk) wreq <= 1'b0;
		wdis <= 1'b1;
		t_sleep(32'h8, 32'h5);
		@(posedge clk) wreq <= 1'b1;
		repeat (3) @(posedge clk);
		#1 `CHK("masked", 1'b0, early)
		t_exit(32'h8, 32'h20);
		@(posedge clk) wreq <= 1'b0;
		wdis <= 1'b0;
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_timed;
		t_late;
		t_ext;
		t_refuse;
		tally_and_finish;
	end
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		tally_and_finish;
	end
endmodule
